//--- hw/rsq_sqw_div.sv
// rsq_sqw_div: square-wave divider from the sampled 32.768 kHz oscillator
`timescale 1ns/1ps
module rsq_sqw_div (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       osc_lvl,
	input  wire logic       osc_rise,
	input  wire logic [3:0] rate_sel,
	input  wire logic       run,
	output logic            sq_out
);

	typedef struct packed {
		logic [14:0] cnt;
		logic        sq;
	} rsq_div_st_t;

	rsq_div_st_t st_q;
	rsq_div_st_t st_d;
	logic [3:0]  tap;

	// bit k-1 of the ripple count has a period of 2^k oscillator cycles
	assign tap = rate_sel - 4'h1;

	// counter is free running so a rate change takes effect without restart
	always_comb begin
		st_d = st_q;
		if (osc_rise) begin
			st_d.cnt = st_q.cnt + 15'h0001;
		end
		if (!run || rate_sel == rsq_pkg::RATE_NONE) begin
			st_d.sq = 1'b0;
		end else if (rate_sel == rsq_pkg::RATE_FULL) begin
			st_d.sq = osc_lvl;
		end else begin
			st_d.sq = st_q.cnt[tap];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sq_out = st_q.sq;

endmodule

//--- hw/rsq_top.sv
// rsq_top: battery check, century and leap logic, oscillator fail flag and square-wave control
`timescale 1ns/1ps
module rsq_top #(
	parameter int OSC_STALL_CYC = rsq_pkg::OSC_STALL_CYC
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// oscillator and supply status
	input  wire logic       osc_in,
	input  wire logic       main_pwr_ok,
	input  wire logic       batt_below_thr,
	// time counter events
	input  wire logic       midnight_roll,
	input  wire logic       century_turn,
	input  wire logic [7:0] year_bcd,
	// outputs
	output logic            sq_wave_pin,
	output logic            batt_load_en,
	output logic            osc_halt_bit,
	output logic            osc_fail_irq,
	output logic      [1:0] century_bits,
	output logic            leap_year
);

	typedef struct packed {
		logic [7:0]               wdog;
		logic [7:0]               almon;
		logic [3:0]               rate;
		logic [1:0]               century;
		logic                     halt;
		logic                     of;
		logic                     bl;
		logic                     load;
		rsq_pkg::rsq_batt_state_t bst;
		logic [15:0]              bcnt;
		logic [23:0]              stall;
		logic                     osc_prev;
		logic                     pwr_prev;
		logic                     irq;
		logic                     leap;
		logic [7:0]               rdata;
	} rsq_top_st_t;

	rsq_top_st_t st_q;
	rsq_top_st_t st_d;

	logic        osc_rise;
	logic        osc_fall;
	logic        osc_stopped;
	logic        pwr_up_evt;
	logic        sq_run;
	logic        wr_flags;
	logic        wr_wdog;
	logic        wr_almon;
	logic        wr_rate;
	logic        wr_century;
	logic        wr_halt;
	logic        osc_fail_irq_en;
	logic        backup_irq_en;
	logic        sq_out_en;
	logic        year_div4;
	logic        year_zero;
	logic [7:0]  flags_view;
	// helper terms feeding the next-state block
	logic        irq_gate;
	logic        fail_clr_req;
	logic        fail_set_evt;
	logic        chk_pwrup_go;
	logic        chk_mid_go;
	logic        settle_done;
	logic [3:0]  wr_rate_val;
	logic [1:0]  wr_century_val;
	logic [7:0]  halt_view;
	logic [7:0]  rate_view;
	logic [7:0]  century_view;
	logic        leap_next;
	logic [23:0] stall_next;
	logic [1:0]  century_next;

	// oscillator edges from the synchronous pin sample
	assign osc_rise = osc_in && !st_q.osc_prev;
	assign osc_fall = !osc_in && st_q.osc_prev;

	// a stall that reaches the window length counts as a stopped oscillator
	assign osc_stopped = (st_q.stall >= 24'(OSC_STALL_CYC));

	// main supply coming up, including release from reset with supply present
	assign pwr_up_evt = main_pwr_ok && !st_q.pwr_prev;

	// register write decodes
	assign wr_flags   = reg_wr && (reg_addr == rsq_pkg::ADDR_FLAGS);
	assign wr_wdog    = reg_wr && (reg_addr == rsq_pkg::ADDR_WDOG);
	assign wr_almon   = reg_wr && (reg_addr == rsq_pkg::ADDR_ALMON);
	assign wr_rate    = reg_wr && (reg_addr == rsq_pkg::ADDR_SQRATE);
	assign wr_century = reg_wr && (reg_addr == rsq_pkg::ADDR_CENTURY);
	assign wr_halt    = reg_wr && (reg_addr == rsq_pkg::ADDR_HALT);

	// control bits held inside the shared registers
	assign osc_fail_irq_en = st_q.wdog[rsq_pkg::OSC_FAIL_IRQ_EN_BIT];
	assign backup_irq_en   = st_q.almon[rsq_pkg::ABE_BIT];
	assign sq_out_en       = st_q.almon[rsq_pkg::SQ_EN_BIT];

	// square wave only while enabled and on main supply
	assign sq_run = sq_out_en && main_pwr_ok;

	// bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
	always_comb begin
		if (year_bcd[4]) begin
			year_div4 = (year_bcd[3:0] == 4'h2) || (year_bcd[3:0] == 4'h6);
		end else begin
			year_div4 = (year_bcd[3:0] == 4'h0) || (year_bcd[3:0] == 4'h4) || (year_bcd[3:0] == 4'h8);
		end
	end

	assign year_zero = (year_bcd == 8'h00);

	// flags view: only battery-low and oscillator-fail live here, the rest read zero
	always_comb begin
		flags_view                   = 8'h00;
		flags_view[rsq_pkg::BL_BIT]  = st_q.bl;
		flags_view[rsq_pkg::OF_BIT]  = st_q.of;
	end

	// the other read views, reserved bits read zero so software can mask blindly
	always_comb begin
		halt_view                               = 8'h00;
		halt_view[rsq_pkg::HALT_BIT]            = st_q.halt;
		rate_view                               = 8'h00;
		rate_view[rsq_pkg::RATE_LSB +: 4]       = st_q.rate;
		century_view                            = 8'h00;
		century_view[rsq_pkg::CENTURY_MSB_BIT]  = st_q.century[1];
		century_view[rsq_pkg::CENTURY_LSB_BIT]  = st_q.century[0];
	end

	// write fields pulled out once so the next-state block stays readable
	assign wr_rate_val    = reg_wdata[rsq_pkg::RATE_LSB +: 4];
	assign wr_century_val = {reg_wdata[rsq_pkg::CENTURY_MSB_BIT], reg_wdata[rsq_pkg::CENTURY_LSB_BIT]};

	// fail flag terms: a clear needs a zero in the flag position, any stop or halt sets
	assign fail_clr_req = wr_flags && !reg_wdata[rsq_pkg::OF_BIT];
	assign fail_set_evt = osc_stopped || st_q.halt;

	// interrupt gate: on main supply the enable alone, in backup the backup enable too
	assign irq_gate = osc_fail_irq_en && (main_pwr_ok || backup_irq_en);

	// battery checks only start while main supply is present, never in backup
	assign chk_pwrup_go = main_pwr_ok && pwr_up_evt;
	assign chk_mid_go   = main_pwr_ok && midnight_roll;

	// end of the settle window under load
	assign settle_done = (st_q.bcnt == 16'(rsq_pkg::BATT_SETTLE_CYC - 1));

	// leap decision for the current year and century
	always_comb begin
		if (year_zero) begin
			leap_next = (st_q.century == 2'h0);
		end else begin
			leap_next = year_div4;
		end
	end

	// stall count: restart on any edge, hold once the window is reached so it never wraps
	always_comb begin
		if (osc_rise || osc_fall) begin
			stall_next = 24'h000000;
		end else if (!osc_stopped) begin
			stall_next = st_q.stall + 24'h000001;
		end else begin
			stall_next = st_q.stall;
		end
	end

	// century next value: a software load wins over the turn in the same cycle
	always_comb begin
		if (wr_century) begin
			century_next = wr_century_val;
		end else if (century_turn) begin
			century_next = st_q.century + 2'h1;
		end else begin
			century_next = st_q.century;
		end
	end

	// next-state logic for the whole block
	always_comb begin
		st_d = st_q;

		// edge and power history
		st_d.osc_prev = osc_in;
		st_d.pwr_prev = main_pwr_ok;

		// stall counter restarts on every oscillator edge and saturates
		st_d.stall = stall_next;

		// plain register stores
		if (wr_wdog) begin
			st_d.wdog = reg_wdata;
		end
		if (wr_almon) begin
			st_d.almon = reg_wdata;
		end
		if (wr_rate) begin
			st_d.rate = wr_rate_val;
		end
		if (wr_halt) begin
			st_d.halt = reg_wdata[rsq_pkg::HALT_BIT];
		end

		// century counter: software load, else binary step at each century turn
		st_d.century = century_next;

		// leap year: divisible by four, a century year only when the field is 00
		st_d.leap = leap_next;

		// oscillator fail flag: a write of zero clears, a stop or halt sets and wins.
		// detection keeps running in backup, there is no supply term here.
		if (fail_clr_req) begin
			st_d.of = 1'b0;
		end
		if (fail_set_evt) begin
			st_d.of = 1'b1;
		end

		// interrupt level: flag and enable, plus backup enable when off main supply.
		// it follows the enable both ways, so re-enabling with the flag up reasserts.
		st_d.irq = st_d.of && irq_gate;

		// battery check sequencer
		case (st_q.bst)
			rsq_pkg::BS_IDLE: begin
				// wait for a start event, nothing is loaded here
				st_d.load = 1'b0;
				st_d.bcnt = 16'h0000;
				if (chk_pwrup_go) begin
					st_d.bst = rsq_pkg::BS_PWRUP;
				end else if (chk_mid_go) begin
					st_d.bst  = rsq_pkg::BS_LOAD;
					st_d.load = 1'b1;
				end
			end
			rsq_pkg::BS_PWRUP: begin
				// compare straight away, the cell already carried the backup load
				st_d.load = 1'b0;
				if (main_pwr_ok) begin
					st_d.bl = batt_below_thr;
				end
				st_d.bst = rsq_pkg::BS_IDLE;
			end
			rsq_pkg::BS_LOAD: begin
				// let the cell settle under load before comparing
				st_d.load = 1'b1;
				if (!main_pwr_ok) begin
					st_d.load = 1'b0;
					st_d.bst  = rsq_pkg::BS_IDLE;
				end else if (settle_done) begin
					st_d.bst = rsq_pkg::BS_SAMPLE;
				end else begin
					st_d.bcnt = st_q.bcnt + 16'h0001;
				end
			end
			rsq_pkg::BS_SAMPLE: begin
				// compare under load, then remove it on the way back to idle
				if (main_pwr_ok) begin
					st_d.bl = batt_below_thr;
				end
				st_d.load = 1'b0;
				st_d.bst  = rsq_pkg::BS_IDLE;
			end
			default: begin
				st_d.load = 1'b0;
				st_d.bst  = rsq_pkg::BS_IDLE;
			end
		endcase

		// read data stands in the cycle after the strobe only
		st_d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				rsq_pkg::ADDR_HALT: begin
					st_d.rdata = halt_view;
				end
				rsq_pkg::ADDR_WDOG: begin
					st_d.rdata = st_q.wdog;
				end
				rsq_pkg::ADDR_ALMON: begin
					st_d.rdata = st_q.almon;
				end
				rsq_pkg::ADDR_FLAGS: begin
					// reading has no side effect on either flag
					st_d.rdata = flags_view;
				end
				rsq_pkg::ADDR_SQRATE: begin
					st_d.rdata = rate_view;
				end
				rsq_pkg::ADDR_CENTURY: begin
					st_d.rdata = century_view;
				end
				default: begin
					st_d.rdata = 8'h00;
				end
			endcase
		end
	end

	// single state register; fail flag comes up set at first power
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q          <= '0;
			st_q.wdog     <= rsq_pkg::WDOG_RST;
			st_q.almon    <= rsq_pkg::ALMON_RST;
			st_q.rate     <= rsq_pkg::RATE_RST;
			st_q.century  <= rsq_pkg::CENTURY_RST;
			st_q.halt     <= rsq_pkg::HALT_RST;
			st_q.of       <= rsq_pkg::OF_RST;
			st_q.bl       <= rsq_pkg::BL_RST;
			st_q.bst      <= rsq_pkg::BS_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// square-wave divider, gated to a static low when not running
	rsq_sqw_div u_div (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.osc_lvl  (osc_in),
		.osc_rise (osc_rise),
		.rate_sel (st_q.rate),
		.run      (sq_run),
		.sq_out   (sq_wave_pin)
	);

	// registered outputs
	assign reg_rdata    = st_q.rdata;
	assign batt_load_en = st_q.load;
	assign osc_halt_bit = st_q.halt;
	assign osc_fail_irq = st_q.irq;
	assign century_bits = st_q.century;
	assign leap_year    = st_q.leap;

endmodule

//--- pkg/rsq_pkg.sv
// rsq_pkg: constants, register map and state types for the rtc status and square-wave block
package rsq_pkg;

	// register addresses on the byte-wide register port
	localparam logic [7:0] ADDR_HALT    = 8'h01;
	localparam logic [7:0] ADDR_WDOG    = 8'h09;
	localparam logic [7:0] ADDR_ALMON   = 8'h0A;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0F;
	localparam logic [7:0] ADDR_SQRATE  = 8'h13;
	localparam logic [7:0] ADDR_CENTURY = 8'h14;

	// field positions
	localparam int HALT_BIT        = 7;
	localparam int OSC_FAIL_IRQ_EN_BIT        = 7;
	localparam int SQ_EN_BIT       = 6;
	localparam int ABE_BIT         = 5;
	localparam int BL_BIT          = 4;
	localparam int OF_BIT          = 2;
	localparam int RATE_LSB        = 4;
	localparam int CENTURY_LSB_BIT = 6;
	localparam int CENTURY_MSB_BIT = 7;

	// values after reset
	localparam logic [7:0] WDOG_RST    = 8'h00;
	localparam logic [7:0] ALMON_RST   = 8'h00;
	localparam logic [3:0] RATE_RST    = 4'h1;
	localparam logic [1:0] CENTURY_RST = 2'h0;
	localparam logic       OF_RST      = 1'b1;
	localparam logic       BL_RST      = 1'b0;
	localparam logic       HALT_RST    = 1'b0;

	// rate codes
	localparam logic [3:0] RATE_NONE = 4'h0;
	localparam logic [3:0] RATE_FULL = 4'h1;

	// timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int OSC_STALL_NS    = 100000;
	localparam int OSC_STALL_CYC   = (OSC_STALL_NS * 1000) / CLK_PERIOD_PS;
	localparam int BATT_SETTLE_NS  = 2000;
	localparam int BATT_SETTLE_CYC = (BATT_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// battery check sequencer
	typedef enum logic [1:0] {
		BS_IDLE,
		BS_PWRUP,
		BS_LOAD,
		BS_SAMPLE
	} rsq_batt_state_t;

endpackage

//--- tb/rsq_osc_model.sv
// rsq_osc_model: crystal stand-in that toggles every HALF clocks while it runs
`timescale 1ns/1ps
module rsq_osc_model #(
	parameter int HALF = 4
) (
	input  wire logic clk,
	input  wire logic osc_run,
	output logic      osc_in
);
	int cnt = 0;
	initial osc_in = 1'b0;
	// a stopped crystal freezes its level, which the stall detector must catch
	always @(posedge clk) begin
		if (osc_run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				osc_in <= ~osc_in;
		end
	end
endmodule

//--- tb/rsq_top_bench.sv
// rsq_top_bench: directed and random checks of the status and square-wave block
`timescale 1ns/1ps
module rsq_top_bench;
	localparam int STALL = 50;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       osc_run = 1'b1;
	logic       main_pwr_ok = 1'b1;
	logic       batt_below_thr = 1'b1;
	logic       midnight_roll = 1'b0;
	logic       century_turn = 1'b0;
	logic [7:0] year_bcd = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] v;
	logic [1:0] century_bits;
	logic       osc_in;
	logic       sq_wave_pin;
	logic       batt_load_en;
	logic       osc_halt_bit;
	logic       osc_fail_irq;
	logic       leap_year;
	int         n_fail = 0;
	int         n_tests = 0;
	int         seed = 28;
	int         n;
	int         e;
	int         y;
	int         c;

	always #2.5 clk = ~clk;
	rsq_osc_model osc_u (.*);
	rsq_top #(.OSC_STALL_CYC(STALL)) dut_u (.*);

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	// strobes start on an edge of their own so two calls never clash
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data only stand in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task rises(input int w);
		logic p;
		n = 0;
		#1;
		p = sq_wave_pin;
		repeat (w) begin
			@(posedge clk);
			#1;
			if (sq_wave_pin && !p)
				n++;
			p = sq_wave_pin;
		end
	endtask

	// rises in 1024 cycles, oscillator period 8 cycles
	function automatic int exp_rises(input int k);
		return (k == 0) ? 0 : (k == 1) ? 128 : (128 >> k);
	endfunction

	function automatic logic exp_leap(input int yr, input int cb);
		return (yr == 0) ? (cb == 0) : (yr % 4 == 0);
	endfunction

	// the whole sequence needs about 20k cycles, so this leaves wide margin
	initial begin
		#250000;
		n_fail++;
		print_verdict;
	end

	initial begin
		tick(8);
		sys_rst <= 1'b0;
		tick(4);
		rd(8'h0F);
		chk("flags", v, 8'h14);
		rd(8'h13);
		chk("rate", v, 8'h10);
		rd(8'h20);
		chk("unmapped", v, 8'h00);
		batt_below_thr <= 1'b0;
		tick(4);
		rd(8'h0F);
		chk("flags", v, 8'h14);
		@(posedge clk);
		midnight_roll <= 1'b1;
		@(posedge clk);
		midnight_roll <= 1'b0;
		#1 chk("load", {7'h00, batt_load_en}, 8'h01);
		for (n = 0; n < 600 && batt_load_en; n++) begin
			@(posedge clk);
			#1;
		end
		rd(8'h0F);
		chk("flags", v, 8'h04);
		// the host forces nothing here: backup must skip the check
		main_pwr_ok <= 1'b0;
		batt_below_thr <= 1'b1;
		@(posedge clk);
		midnight_roll <= 1'b1;
		@(posedge clk);
		midnight_roll <= 1'b0;
		tick(3);
		#1 chk("load", {7'h00, batt_load_en}, 8'h00);
		rd(8'h0F);
		chk("flags", v, 8'h04);
		main_pwr_ok <= 1'b1;
		tick(4);
		rd(8'h0F);
		chk("flags", v, 8'h14);
		wr(8'h0F, 8'h00);
		wr(8'h0F, 8'hFF);
		rd(8'h0F);
		chk("flags", v, 8'h10);
		wr(8'h09, 8'h80);
		osc_run <= 1'b0;
		tick(STALL + 10);
		#1 chk("irq", {7'h00, osc_fail_irq}, 8'h01);
		rd(8'h0F);
		chk("flags", v, 8'h14);
		wr(8'h09, 8'h00);
		tick(2);
		#1 chk("irq", {7'h00, osc_fail_irq}, 8'h00);
		wr(8'h09, 8'h80);
		tick(2);
		#1 chk("irq", {7'h00, osc_fail_irq}, 8'h01);
		osc_run <= 1'b1;
		// scaled-down settling time before the host clears the flag
		tick(10);
		wr(8'h0F, 8'h00);
		tick(2);
		#1 chk("irq", {7'h00, osc_fail_irq}, 8'h00);
		wr(8'h01, 8'h80);
		tick(3);
		#1 chk("halt", {7'h00, osc_halt_bit}, 8'h01);
		rd(8'h0F);
		chk("flags", v, 8'h14);
		wr(8'h01, 8'h00);
		tick(5);
		wr(8'h0F, 8'h00);
		rd(8'h0F);
		chk("flags", v, 8'h10);
		wr(8'h0A, 8'h00);
		main_pwr_ok <= 1'b0;
		osc_run <= 1'b0;
		tick(STALL + 10);
		#1 chk("irq", {7'h00, osc_fail_irq}, 8'h00);
		rd(8'h0F);
		chk("flags", v, 8'h14);
		wr(8'h0A, 8'h20);
		tick(2);
		#1 chk("irq", {7'h00, osc_fail_irq}, 8'h01);
		main_pwr_ok <= 1'b1;
		osc_run <= 1'b1;
		wr(8'h09, 8'h00);
		for (int k = 0; k < 16; k++) begin
			wr(8'h13, {4'(k), 4'h0});
			wr(8'h0A, 8'h40);
			tick(4);
			rises(1024);
			e = exp_rises(k);
			chk("sq", (n >= e - 1 && n <= e + 1) ? 8'(e) : 8'(n), 8'(e));
		end
		wr(8'h13, 8'h10);
		wr(8'h0A, 8'h00);
		tick(4);
		rises(64);
		chk("sq", 8'(n), 8'h00);
		wr(8'h0A, 8'h40);
		main_pwr_ok <= 1'b0;
		tick(4);
		rises(64);
		chk("sq", 8'(n), 8'h00);
		main_pwr_ok <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			y = (i < 4) ? 0 : {$random(seed)} % 100;
			c = (i < 4) ? i : {$random(seed)} % 4;
			year_bcd <= {4'(y / 10), 4'(y % 10)};
			wr(8'h14, {2'(c), 6'h00});
			tick(2);
			#1 chk("century", {6'h00, century_bits}, 8'(c));
			chk("leap", {7'h00, leap_year}, {7'h00, exp_leap(y, c)});
			@(posedge clk);
			century_turn <= 1'b1;
			@(posedge clk);
			century_turn <= 1'b0;
			#1 chk("century", {6'h00, century_bits}, 8'((c + 1) % 4));
		end
		print_verdict;
	end
endmodule

//--- tb/rsq_top_sva.sv
// rsq_top_sva: port-level checker for the status and square-wave block
`timescale 1ns/1ps
module rsq_chk #(
	parameter int OSC_STALL_CYC = 50
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       main_pwr_ok,
	input wire logic       midnight_roll,
	input wire logic       century_turn,
	input wire logic       sq_wave_pin,
	input wire logic       batt_load_en,
	input wire logic       osc_halt_bit,
	input wire logic       osc_fail_irq,
	input wire logic [1:0] century_bits
);
	logic [15:0] ld_cnt_q;
	// length of the current load pulse, too long for a repetition
	always_ff @(posedge clk) begin
		if (sys_rst)
			ld_cnt_q <= 16'h0000;
		else
			ld_cnt_q <= batt_load_en ? ld_cnt_q + 16'h0001 : 16'h0000;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_sq_backup: assert property (!main_pwr_ok [*3] |-> !sq_wave_pin)
		else $error("square pin active in backup");
	chk_load_backup: assert property (!main_pwr_ok [*3] |-> !batt_load_en)
		else $error("battery load in backup");
	chk_load_start: assert property ($rose(batt_load_en) |-> $past(midnight_roll) && $past(main_pwr_ok))
		else $error("battery load without midnight");
	chk_load_len: assert property ($fell(batt_load_en) && $past(main_pwr_ok) |->
		ld_cnt_q == 16'(rsq_pkg::BATT_SETTLE_CYC + 1))
		else $error("battery load length wrong");
	chk_century_inc: assert property (century_turn && !(reg_wr && reg_addr == 8'h14) |=>
		century_bits == $past(century_bits) + 2'h1)
		else $error("century did not count");
	chk_century_hold: assert property (!century_turn && !reg_wr |=> $stable(century_bits))
		else $error("century changed by itself");
	chk_irq_drop: assert property (reg_wr && reg_addr == 8'h09 && !reg_wdata[7] |-> ##[1:2] !osc_fail_irq)
		else $error("interrupt kept after enable cleared");
	chk_halt_wr: assert property (reg_wr && reg_addr == 8'h01 |=> osc_halt_bit == $past(reg_wdata[7]))
		else $error("halt bit not taken");
	cover property ($fell(batt_load_en));
	cover property ($rose(osc_fail_irq));
	cover property (century_turn);
endmodule

bind rsq_top rsq_chk #(.OSC_STALL_CYC(OSC_STALL_CYC)) chk_u (.*);
